// ==== logic/shmem_protect_consts.svh ====
// constants for the shared memory core protection block: offsets, fields, resets
// assumes inclusion by bare name from the design module
`ifndef SHMEM_PROTECT_CONSTS_SVH
`define SHMEM_PROTECT_CONSTS_SVH

// register offsets on the core register port
`define OFS_CORE_CTRL        16'hF900
`define OFS_TOP_SIZE         16'hF902
`define OFS_SEMAPHORE        16'hF904
`define OFS_OVR_LOW          16'hF910
`define OFS_OVR_MID          16'hF912
`define OFS_OVR_HIGH         16'hF914

// reset values
`define SIZE_RESET           5'h02
`define SIZE_RESET_FORCED    5'h00
`define SEM_RESET            8'h00
`define CTRL_RESP_RESET      2'h0
`define OVR_ALL_ONES         48'hFFFF_FFFF_FFFF

// field positions
`define CTRL_FLAG_BIT        6
`define CTRL_RESP_LSB        3
`define CTRL_RESP_MSB        4
`define SIZE_MSB             4
`define SEM_HOST_MSB         3
`define SEM_CORE_LSB         4
`define SEM_CORE_MSB         7

// block geometry
`define LOW_BLOCK_SHIFT      13
`define BIG_BLOCK_SHIFT      16
`define LOW_BLOCK_COUNT      16
`define OVR_BITS             48
`define LOCKED_LOW_BIT       7
`define MID_RESERVED_LO      16
`define MID_RESERVED_HI      17

`endif

// ==== logic/shmem_protect_pkg.sv ====
// types shared by the shared memory core protection block and its bench
// assumes the constants header sits beside it
package shmem_protect_pkg;
    // operating environment of the embedded core
    typedef enum logic [1:0] {
        ENV_DEVELOPMENT,
        ENV_IN_SYSTEM,
        ENV_ON_BOARD_DEBUG
    } env_t;

    // answer given to a host read request
    typedef enum logic [1:0] {
        ANS_READ_OK,
        ANS_LONG_WAIT,
        ANS_ZERO_READ,
        ANS_ERROR_SYNC
    } answer_t;
endpackage : shmem_protect_pkg

// ==== logic/shared_memory_core_protect.sv ====
// core-side size, semaphore and read-override registers of the shared memory
// assumes one clock, host side events already synchronous to it, and a
// protection word presented as steady levels from power-up onward
//
// Contract
// - size field counts 64 KB main block units
// - top address is first address past block
// - size register reset only by power-up
// - size resets to 2, or 0 when forced
// - size writable only in development environment
// - host flags written by host, core reads
// - core flags read/write core, host reads
// - semaphore register clears to zero on reset
// - host read needs both protect bits clear
// - low blocks 8 KB, others 64 KB
// - three 16-bit override registers, reserved bits zero
// - override one blocks host read always
// - low register bit 7 is read-only
// - reset pattern: core boot 1, host boot 0
// - boot block override bits are read-only
// - overrides reload on reset and size change
// - host boot uses size-derived top address
// - host flag write sets sticky write-one-clear flag
// - protected read answered per error response field
`timescale 1ns/1ps
`include "shmem_protect_consts.svh"

module shared_memory_core_protect (
    input  wire  logic                       clock,           // core clock, 250 MHz
    input  wire  logic                       rst_n,           // general reset, async
    input  wire  logic                       por_n,           // supply power-up reset, async
    input  wire  shmem_protect_pkg::env_t    env,             // core environment
    input  wire  logic                       force_top_zero,  // protection word strap
    input  wire  logic [7:0]                 core_boot_size,  // core boot size, 8 KB units
    input  wire  logic [7:0]                 host_boot_size,  // host boot size, 8 KB units
    input  wire  logic [15:0]                reg_addr,        // register offset
    input  wire  logic [15:0]                reg_wdata,       // register write data
    input  wire  logic                       reg_wr,          // write strobe
    input  wire  logic                       reg_rd,          // read strobe
    output logic [15:0]                      reg_rdata,       // read data, cycle after strobe
    input  wire  logic                       host_sem_wr,     // host writes its flags
    input  wire  logic [3:0]                 host_sem_wdata,  // host flag data
    output logic [7:0]                       sem_to_host,     // semaphore value for host
    input  wire  logic                       host_rd_req,     // host read request
    input  wire  logic [20:0]                host_rd_addr,    // host read address
    input  wire  logic                       host_rd_protect, // host-set protect bit of block
    output logic                             host_rd_done,    // answer pulse
    output shmem_protect_pkg::answer_t       host_rd_answer,  // answer kind
    output logic [20:0]                      main_top_address // first address past main block
);
    import shmem_protect_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helper functions

    // start address of override bit k; low bits are 8 KB, the rest 64 KB
    function automatic logic [21:0] block_start(input int k);
        if (k < `LOW_BLOCK_COUNT)
            block_start = 22'(k) << `LOW_BLOCK_SHIFT;
        else
            block_start = 22'(k - `LOW_BLOCK_COUNT) << `BIG_BLOCK_SHIFT;
    endfunction : block_start

    // classify bit k as {core boot, host boot} for the given sizes
    function automatic logic [1:0] block_class(
        input int          k,
        input logic [4:0]  size,
        input logic [7:0]  core_sz,
        input logic [7:0]  host_sz
    );
        logic [21:0] bstart;
        logic [21:0] bend;
        logic [21:0] core_end;
        logic [21:0] top;
        logic [21:0] host_len;
        logic [21:0] host_lo;
        logic        is_core;
        bstart   = block_start(k);
        // the next index past low block 15 is big block 0, which starts at zero
        bend     = bstart + ((k < `LOW_BLOCK_COUNT) ? 22'h002000 : 22'h010000);
        core_end = {1'b0, core_sz, 13'h0000};
        top      = {1'b0, size, 16'h0000};
        host_len = {1'b0, host_sz, 13'h0000};
        host_lo  = (host_len > top) ? 22'h000000 : top - host_len;
        is_core  = bstart < core_end;
        block_class = {is_core, !is_core && (bstart < top) && (bend > host_lo)};
    endfunction : block_class

    // override bit index that covers a host address
    function automatic logic [5:0] addr_to_index(input logic [20:0] addr);
        if (addr[20:17] == 4'h0)
            addr_to_index = {2'h0, addr[16:13]};
        else
            addr_to_index = 6'h10 + {1'b0, addr[20:16]};
    endfunction : addr_to_index

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    logic        sel_ctrl;
    logic        sel_size;
    logic        sel_sem;
    logic        sel_low;
    logic        sel_mid;
    logic        sel_high;
    logic [2:0]  ovr_wr_hit;

    // one select per register, shared by the read and write paths
    assign sel_ctrl   = (reg_addr == `OFS_CORE_CTRL);
    assign sel_size   = (reg_addr == `OFS_TOP_SIZE);
    assign sel_sem    = (reg_addr == `OFS_SEMAPHORE);
    assign sel_low    = (reg_addr == `OFS_OVR_LOW);
    assign sel_mid    = (reg_addr == `OFS_OVR_MID);
    assign sel_high   = (reg_addr == `OFS_OVR_HIGH);
    assign ovr_wr_hit = {3{reg_wr}} & {sel_high, sel_mid, sel_low};

    ////////////////////////////////////////////////////////////////////////////
    // main block size, power-up domain only

    logic [4:0]  size_ff;
    logic        size_loaded_ff;
    logic [4:0]  nxt_size;
    logic [4:0]  strap_size;
    logic        size_wr_ok;

    // the strap cannot feed the async reset, so it is caught on the first edge
    assign strap_size = force_top_zero ? `SIZE_RESET_FORCED : `SIZE_RESET;
    assign size_wr_ok = reg_wr && sel_size && (env == ENV_DEVELOPMENT);
    assign nxt_size   = !size_loaded_ff ? strap_size
                      : size_wr_ok      ? reg_wdata[`SIZE_MSB:0]
                      : size_ff;

    // general reset does not reach this register
    always_ff @(posedge clock or negedge por_n)
    begin
        if (!por_n)
        begin
            size_ff        <= 5'h00;
            size_loaded_ff <= 1'b0;
        end
        else
        begin
            size_ff        <= nxt_size;
            size_loaded_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general reset domain: power-up also resets everything here

    logic        sys_rst_n;
    assign sys_rst_n = rst_n & por_n;

    ////////////////////////////////////////////////////////////////////////////
    // read override bits, flattened: low 0-15, mid 16-31, high 32-47

    logic [47:0] ovr_ff;
    logic [47:0] nxt_ovr;
    logic [47:0] ovr_ro;
    logic [47:0] ovr_rst_pat;
    logic [4:0]  size_seen_ff;
    logic        reload_pend_ff;
    logic        reload;

    // a size change or a fresh reset reloads the whole pattern
    assign reload = reload_pend_ff || (size_ff != size_seen_ff);

    generate
        for (genvar k = 0; k < `OVR_BITS; k++)
        begin : g_ovr
            logic [1:0] cls;
            assign cls = block_class(k, size_ff, core_boot_size, host_boot_size);
            if (k == `MID_RESERVED_LO || k == `MID_RESERVED_HI)
            begin : g_rsvd
                // reserved mid bits stay zero
                assign ovr_ro[k]      = 1'b1;
                assign ovr_rst_pat[k] = 1'b0;
            end
            else if (k == `LOCKED_LOW_BIT)
            begin : g_locked
                assign ovr_ro[k]      = 1'b1;
                assign ovr_rst_pat[k] = 1'b1;
            end
            else
            begin : g_norm
                assign ovr_ro[k]      = cls[1] | cls[0];
                assign ovr_rst_pat[k] = !cls[0];
            end
            // read-only bits keep their value on a core write
            assign nxt_ovr[k] = reload ? ovr_rst_pat[k]
                              : (ovr_wr_hit[k / 16] && !ovr_ro[k])
                                ? reg_wdata[k % 16]
                              : ovr_ff[k];
        end
    endgenerate

    // async reset leaves all blocks closed until the pattern loads next edge
    always_ff @(posedge clock or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            ovr_ff         <= `OVR_ALL_ONES;
            size_seen_ff   <= 5'h00;
            reload_pend_ff <= 1'b1;
        end
        else
        begin
            ovr_ff         <= nxt_ovr;
            size_seen_ff   <= size_ff;
            reload_pend_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // semaphores and core control

    logic [7:0]  sem_ff;
    logic [7:0]  nxt_sem;
    logic        flag_ff;
    logic        nxt_flag;
    logic [1:0]  resp_ff;
    logic [1:0]  nxt_resp;
    logic        ctrl_wr;
    logic        sem_wr;

    assign ctrl_wr  = reg_wr && sel_ctrl;
    assign sem_wr   = reg_wr && sel_sem;
    // host owns the low nibble, core the high one; core writes to low are dropped
    assign nxt_sem[`SEM_HOST_MSB:0] = host_sem_wr ? host_sem_wdata
                                    : sem_ff[`SEM_HOST_MSB:0];
    assign nxt_sem[`SEM_CORE_MSB:`SEM_CORE_LSB] =
        sem_wr ? reg_wdata[`SEM_CORE_MSB:`SEM_CORE_LSB]
               : sem_ff[`SEM_CORE_MSB:`SEM_CORE_LSB];
    // set beats a same-cycle write-one clear
    assign nxt_flag = host_sem_wr ||
                      (flag_ff && !(ctrl_wr && reg_wdata[`CTRL_FLAG_BIT]));
    assign nxt_resp = ctrl_wr ? reg_wdata[`CTRL_RESP_MSB:`CTRL_RESP_LSB] : resp_ff;

    always_ff @(posedge clock or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            sem_ff  <= `SEM_RESET;
            flag_ff <= 1'b0;
            resp_ff <= `CTRL_RESP_RESET;
        end
        else
        begin
            sem_ff  <= nxt_sem;
            flag_ff <= nxt_flag;
            resp_ff <= nxt_resp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read path

    logic [15:0] ctrl_view;
    logic [15:0] nxt_rdata;
    logic [15:0] reg_rdata_ff;

    assign ctrl_view = {9'h000, flag_ff, 1'b0, resp_ff, 3'h0};
    // unmapped offsets and idle cycles read zero
    assign nxt_rdata = !reg_rd  ? 16'h0000
                     : sel_ctrl ? ctrl_view
                     : sel_size ? {11'h000, size_ff}
                     : sel_sem  ? {8'h00, sem_ff}
                     : sel_low  ? ovr_ff[15:0]
                     : sel_mid  ? ovr_ff[31:16]
                     : sel_high ? ovr_ff[47:32]
                     : 16'h0000;

    always_ff @(posedge clock or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
            reg_rdata_ff <= 16'h0000;
        else
            reg_rdata_ff <= nxt_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // host read check

    logic [5:0]  rd_idx;
    logic        rd_blocked;
    answer_t     deny_answer;
    answer_t     nxt_answer;
    logic        host_rd_done_ff;
    answer_t     host_rd_answer_ff;
    logic [20:0] top_addr_ff;

    assign rd_idx     = addr_to_index(host_rd_addr);
    assign rd_blocked = host_rd_protect || ovr_ff[rd_idx];
    // reserved response code behaves like the long wait
    assign deny_answer = (resp_ff == 2'h1) ? ANS_ZERO_READ
                       : (resp_ff == 2'h2) ? ANS_ERROR_SYNC
                       : ANS_LONG_WAIT;
    assign nxt_answer  = rd_blocked ? deny_answer : ANS_READ_OK;

    always_ff @(posedge clock or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            host_rd_done_ff   <= 1'b0;
            host_rd_answer_ff <= ANS_READ_OK;
            top_addr_ff       <= 21'h000000;
        end
        else
        begin
            host_rd_done_ff   <= host_rd_req;
            if (host_rd_req)
                host_rd_answer_ff <= nxt_answer;
            top_addr_ff       <= {size_ff, 16'h0000};
        end
    end

    assign reg_rdata        = reg_rdata_ff;
    assign sem_to_host      = sem_ff;
    assign host_rd_done     = host_rd_done_ff;
    assign host_rd_answer   = host_rd_answer_ff;
    assign main_top_address = top_addr_ff;

endmodule : shared_memory_core_protect

// ==== verification/shmem_protect_asserts.sv ====
// concurrent checks on the ports of the shared memory core protection block
// assumes one clock and two active-low resets; bound to the top module
`timescale 1ns/1ps
module shmem_protect_asserts (
    input wire logic                 clock,            // core clock
    input wire logic                 rst_n,            // general reset
    input wire logic                 por_n,            // power-up reset
    input wire logic [15:0]          reg_addr,         // register offset
    input wire logic [15:0]          reg_wdata,        // write data
    input wire logic                 reg_wr,           // write strobe
    input wire logic                 reg_rd,           // read strobe
    input wire logic [15:0]          reg_rdata,        // read data
    input wire logic                 host_sem_wr,      // host flag write
    input wire logic [3:0]           host_sem_wdata,   // host flag data
    input wire logic [7:0]           sem_to_host,      // semaphore value
    input wire logic                 host_rd_req,      // host read request
    input wire logic                 host_rd_protect,  // host protect bit
    input wire logic                 host_rd_done,     // answer pulse
    input shmem_protect_pkg::answer_t host_rd_answer,  // answer kind
    input wire logic [20:0]          main_top_address  // top address
);
    import shmem_protect_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !por_n);

    // read port and size readback
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_top_from_size: assert property (reg_rd && reg_addr == 16'hF902
        |=> reg_rdata == {11'h000, main_top_address[20:16]} && main_top_address[15:0] == 16'h0000)
        else $error("top address does not match size field");
    // host read answers
    a_done_follows_req: assert property (host_rd_req |=> host_rd_done)
        else $error("host read not answered in one cycle");
    a_done_has_cause: assert property (host_rd_done |-> $past(host_rd_req))
        else $error("answer pulse without request");
    a_protect_blocks_read: assert property (host_rd_req && host_rd_protect
        |=> host_rd_answer != ANS_READ_OK)
        else $error("protected host read allowed");
    // semaphore ownership
    a_host_flag_write: assert property (host_sem_wr
        |=> sem_to_host[3:0] == $past(host_sem_wdata))
        else $error("host flags not taken");
    a_host_flag_hold: assert property (!host_sem_wr |=> $stable(sem_to_host[3:0]))
        else $error("host flags changed without host write");
    a_core_flag_write: assert property (reg_wr && reg_addr == 16'hF904
        |=> sem_to_host[7:4] == $past(reg_wdata[7:4]))
        else $error("core flags not taken");
    a_core_flag_hold: assert property (!(reg_wr && reg_addr == 16'hF904)
        |=> $stable(sem_to_host[7:4]))
        else $error("core flags changed without core write");

    c_blocked_read: cover property (host_rd_done && host_rd_answer != ANS_READ_OK);
    c_host_flag: cover property (host_sem_wr);
    c_size_write: cover property (reg_wr && reg_addr == 16'hF902);
endmodule : shmem_protect_asserts

bind shared_memory_core_protect shmem_protect_asserts shmem_protect_asserts_i (
    .clock, .rst_n, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_sem_wr, .host_sem_wdata, .sem_to_host, .host_rd_req, .host_rd_protect,
    .host_rd_done, .host_rd_answer, .main_top_address);

// ==== verification/shmem_host_model.sv ====
// host side model: flag writes and read requests, one cycle after the bench asks
// assumes bench requests are single-cycle pulses on go_sem and go_rd
`timescale 1ns/1ps
module shmem_host_model (
    input  wire logic        clock,           // core clock
    input  wire logic        rst_n,           // combined reset
    input  wire logic        go_sem,          // bench asks flag write
    input  wire logic [3:0]  sem_val,         // flag value
    input  wire logic        go_rd,           // bench asks read
    input  wire logic [20:0] rd_addr,         // read address
    input  wire logic        rd_prot,         // host protect bit
    output logic             host_sem_wr,     // flag write pulse
    output logic [3:0]       host_sem_wdata,  // flag data
    output logic             host_rd_req,     // read pulse
    output logic [20:0]      host_rd_addr,    // read address
    output logic             host_rd_protect  // protect bit
);
    // idle lines flip so a stale value never looks valid
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_sem_wr     <= 1'b0;
            host_sem_wdata  <= 4'h0;
            host_rd_req     <= 1'b0;
            host_rd_addr    <= 21'h000000;
            host_rd_protect <= 1'b0;
        end
        else
        begin
            host_sem_wr     <= go_sem;
            host_sem_wdata  <= go_sem ? sem_val : ~host_sem_wdata;
            host_rd_req     <= go_rd;
            host_rd_addr    <= go_rd ? rd_addr : ~host_rd_addr;
            host_rd_protect <= go_rd ? rd_prot : ~host_rd_protect;
        end
    end
endmodule : shmem_host_model

// ==== verification/shared_memory_core_protect_test.sv ====
// self-checking bench for the shared memory core protection block
// assumes the host model on the host ports and a bound port checker
`timescale 1ns/1ps
module shared_memory_core_protect_test;
    import shmem_protect_pkg::*;
    logic        clock, rst_n, por_n, force_top_zero, reg_wr, reg_rd, go_sem, go_rd, rd_prot;
    logic        host_sem_wr, host_rd_req, host_rd_protect, host_rd_done;
    env_t        env;
    answer_t     host_rd_answer;
    logic [7:0]  core_boot_size, host_boot_size, sem_to_host;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [3:0]  host_sem_wdata, sem_val;
    logic [20:0] host_rd_addr, main_top_address, rd_addr;
    logic [47:0] ovr, ro;
    logic [31:0] seed;
    int          error_cnt, n_compared;

    shared_memory_core_protect shared_memory_core_protect_i (.clock, .rst_n, .por_n, .env,
        .force_top_zero, .core_boot_size, .host_boot_size, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .host_sem_wr, .host_sem_wdata, .sem_to_host, .host_rd_req,
        .host_rd_addr, .host_rd_protect, .host_rd_done, .host_rd_answer, .main_top_address);
    shmem_host_model shmem_host_model_i (.clock, .rst_n(rst_n & por_n), .go_sem, .sem_val,
        .go_rd, .rd_addr, .rd_prot, .host_sem_wr, .host_sem_wdata, .host_rd_req,
        .host_rd_addr, .host_rd_protect);

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // {read-only, reset value} of override bit k for a given size field
    function logic [1:0] blk(input int k, input int size);
        int s, e, hl;
        s = (k < 16) ? k * 8192 : (k - 16) * 65536;
        e = s + ((k < 16) ? 8192 : 65536);
        hl = size * 65536 - 8192 * int'(host_boot_size);
        if (k == 16 || k == 17) return 2'h2;
        if (s < 8192 * int'(core_boot_size) || k == 7) return 2'h3;
        if (s < size * 65536 && e > hl) return 2'h2;
        return 2'h1;
    endfunction : blk
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task rdc(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc
    task reload(input int size);
        for (int k = 0; k < 48; k++) {ro[k], ovr[k]} = blk(k, size);
    endtask : reload
    task chk_ovr;
        for (int r = 0; r < 3; r++)
            rdc(16'hF910 + 16'(2 * r), ovr[16 * r +: 16]);
    endtask : chk_ovr
    task host_batch(input int resp, input int n);
        int k;
        answer_t exp;
        repeat (n)
        begin
            seed = lfsr(seed);
            k = (seed[20:0] < 21'h020000) ? int'(seed[16:13]) : 16 + int'(seed[20:16]);
            exp = ANS_READ_OK;
            if (seed[31] || ovr[k])
                exp = (resp == 1) ? ANS_ZERO_READ : (resp == 2) ? ANS_ERROR_SYNC : ANS_LONG_WAIT;
            @(posedge clock);
            go_rd <= 1'b1;
            rd_addr <= seed[20:0];
            rd_prot <= seed[31];
            @(posedge clock);
            go_rd <= 1'b0;
            @(posedge clock);
            #1;
            chk(host_rd_done, 1'b1);
            chk(host_rd_answer, exp);
        end
    endtask : host_batch
    task summarize;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        summarize;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, por_n, force_top_zero, reg_wr, reg_rd, go_sem, go_rd, rd_prot} = 8'h00;
        {reg_addr, reg_wdata, sem_val, rd_addr} = 57'h0;
        {core_boot_size, host_boot_size, seed} = {8'h02, 8'h04, 32'h38FA};
        env = ENV_DEVELOPMENT;
        error_cnt = 0;
        n_compared = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(16'hF902, 16'h0002);
        chk(main_top_address, 21'h020000);
        rdc(16'hF904, 16'h0000);
        rdc(16'hF906, 16'h0000);
        reload(2);
        chk_ovr;
        // zeros, ones, then random data against the read-only mask
        for (int i = 0; i < 5; i++)
        begin
            for (int r = 0; r < 3; r++)
            begin
                seed = lfsr(seed);
                rv = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
                wr(16'hF910 + 16'(2 * r), rv);
                for (int b = 0; b < 16; b++) if (!ro[16 * r + b]) ovr[16 * r + b] = rv[b];
            end
            chk_ovr;
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(16'hF900, 16'(i) << 3);
            rdc(16'hF900, 16'(i) << 3);
            host_batch(i, 12);
        end
        wr(16'hF904, 16'hFFFF);
        rdc(16'hF904, 16'h00F0);
        @(posedge clock);
        go_sem <= 1'b1;
        sem_val <= 4'hA;
        @(posedge clock);
        go_sem <= 1'b0;
        @(posedge clock);
        #1;
        chk(sem_to_host, 8'hFA);
        rdc(16'hF900, 16'h0058);
        wr(16'hF900, 16'h0058);
        rdc(16'hF900, 16'h0018);
        wr(16'hF902, 16'h0005);
        rdc(16'hF902, 16'h0005);
        chk(main_top_address, 21'h050000);
        reload(5);
        chk_ovr;
        host_batch(3, 12);
        env <= ENV_IN_SYSTEM;
        wr(16'hF902, 16'h0003);
        rdc(16'hF902, 16'h0005);
        env <= ENV_ON_BOARD_DEBUG;
        wr(16'hF902, 16'h0009);
        rdc(16'hF902, 16'h0005);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdc(16'hF902, 16'h0005);
        rdc(16'hF904, 16'h0000);
        chk_ovr;
        force_top_zero <= 1'b1;
        por_n <= 1'b0;
        repeat (3) @(posedge clock);
        por_n <= 1'b1;
        repeat (4) @(posedge clock);
        rdc(16'hF902, 16'h0000);
        chk(main_top_address, 21'h000000);
        reload(0);
        chk_ovr;
        summarize;
    end
endmodule : shared_memory_core_protect_test
